// [rtl/pfer_event_reporter.sv]
// port fault event reporter: sticky event flags, interrupt and port-write request
// assumes all event strobes come from port and fabric logic on i_clk_sys
module pfer_event_reporter #(
    parameter int LANES = pfer_pkg::LANES_DEF,
    parameter int FAB_SRC = pfer_pkg::FAB_SRC_DEF,
    parameter int SEQ_W = pfer_pkg::SEQ_W_DEF
)
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // internal switching fabric events
    input wire logic i_fabric_req_timeout,
    input wire logic [FAB_SRC-1:0] i_fabric_timeout_src,
    input wire logic i_replication_timeout,
    // link maintenance
    input wire logic i_lreq_sent,
    input wire logic i_lresp_rx,
    input wire logic [pfer_pkg::TIMEOUT_W-1:0] i_lresp_timeout_cycles,
    input wire logic i_dead_link_expired,
    input wire logic [LANES-1:0] i_lane_sync_expired,
    input wire logic i_link_init_done,
    input wire logic i_peer_present,
    // outstanding sequence window and received control symbols
    input wire logic [SEQ_W-1:0] i_seq_oldest,
    input wire logic [SEQ_W:0] i_seq_outstanding,
    input wire logic i_cs_rx,
    input wire logic [1:0] i_cs_kind,
    input wire logic [SEQ_W-1:0] i_cs_seq,
    // software control
    input wire logic [pfer_pkg::EVT_COUNT-1:0] i_evt_clear,
    input wire logic [FAB_SRC-1:0] i_fabric_clear,
    input wire logic [pfer_pkg::EVT_COUNT-1:0] i_irq_enable,
    input wire logic [pfer_pkg::EVT_COUNT-1:0] i_pw_enable,
    input wire logic i_pw_permit,
    input wire logic i_pw_ack,
    // fabric drop command
    output logic o_drop_packet,
    // sticky event flags
    output logic o_fabric_timeout_drop,
    output logic o_egress_discard,
    output logic o_global_fabric_timeout,
    output logic o_replication_timeout,
    output logic o_port_fault,
    output logic o_ack_wait_expired,
    output logic o_link_reply_bad_sequence,
    output logic o_peer_link_up_notice,
    output logic o_ctrl_symbol_unused_sequence,
    output logic [FAB_SRC-1:0] o_fabric_int_status,
    output logic [LANES-1:0] o_lane_sync_fault,
    // notification
    output logic o_irq,
    output logic o_port_write_req,
    output logic [pfer_pkg::EVT_COUNT-1:0] o_port_write_events
);

    localparam int N = pfer_pkg::EVT_COUNT;

    logic resp_timeout;
    logic bad_seq_resp;
    logic lreq_fatal;
    logic no_outstanding;
    logic [SEQ_W-1:0] seq_dist;
    logic seq_in_use;
    logic cs_checked;
    logic [LANES-1:0] lane_rise;
    logic link_up_rise;
    logic fatal_now;
    logic [N-1:0] evt_set;
    logic [N-1:0] pw_new;

    logic [N-1:0] flags_q, flags_d;
    logic [FAB_SRC-1:0] fab_q, fab_d;
    logic [LANES-1:0] lane_prev_q, lane_prev_d;
    logic [LANES-1:0] lane_fault_q, lane_fault_d;
    logic init_prev_q, init_prev_d;
    logic dead_prev_q, dead_prev_d;
    logic drop_q, drop_d;
    logic irq_q, irq_d;
    logic pw_req_q, pw_req_d;
    logic [N-1:0] pw_evt_q, pw_evt_d;

    ////////////////////////////////////////////////////////////////////////////////
    // link-request retry tracking
    pfer_lreq_tracker #(
        .TRIES(pfer_pkg::LREQ_TRIES)
    )
    u_lreq_tracker (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_lreq_sent(i_lreq_sent),
        .i_lresp_rx(i_lresp_rx),
        .i_no_outstanding(no_outstanding),
        .i_timeout_cycles(i_lresp_timeout_cycles),
        .o_resp_timeout(resp_timeout),
        .o_bad_seq_resp(bad_seq_resp),
        .o_fatal(lreq_fatal)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // sequence window check
    assign no_outstanding = (i_seq_outstanding == '0);
    assign seq_dist = i_cs_seq - i_seq_oldest;
    assign seq_in_use = ({1'b0, seq_dist} < i_seq_outstanding);
    // only acceptance, non-acceptance and retry symbols are checked
    assign cs_checked = i_cs_rx && (i_cs_kind != pfer_pkg::CS_OTHER);

    ////////////////////////////////////////////////////////////////////////////////
    // per-lane sync timer expiry edges
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            assign lane_rise[g] = i_lane_sync_expired[g] && !lane_prev_q[g];
            // lane record sticks until the port fault flag is cleared
            always_comb
            begin
                lane_prev_d[g] = i_lane_sync_expired[g];
                lane_fault_d[g] = lane_fault_q[g];
                if (i_evt_clear[pfer_pkg::EVT_PORT_FAULT])
                begin
                    lane_fault_d[g] = 1'b0;
                end
                if (lane_rise[g])
                begin
                    lane_fault_d[g] = 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            lane_prev_q <= '0;
            lane_fault_q <= '0;
        end
        else
        begin
            lane_prev_q <= lane_prev_d;
            lane_fault_q <= lane_fault_d;
        end
    end

    assign link_up_rise = i_link_init_done && i_peer_present && !init_prev_q;

    // any fatal condition of the port
    assign fatal_now = lreq_fatal
        || (i_dead_link_expired && !dead_prev_q)
        || (|lane_rise);

    ////////////////////////////////////////////////////////////////////////////////
    // event set vector
    always_comb
    begin
        evt_set = '0;
        evt_set[pfer_pkg::EVT_FABRIC_TIMEOUT_DROP] = i_fabric_req_timeout;
        evt_set[pfer_pkg::EVT_EGRESS_DISCARD] = i_fabric_req_timeout;
        evt_set[pfer_pkg::EVT_GLOBAL_FABRIC_TIMEOUT] = i_fabric_req_timeout;
        evt_set[pfer_pkg::EVT_REPLICATION_TIMEOUT] = i_replication_timeout;
        evt_set[pfer_pkg::EVT_PORT_FAULT] = fatal_now;
        evt_set[pfer_pkg::EVT_ACK_WAIT_EXPIRED] = resp_timeout;
        evt_set[pfer_pkg::EVT_LINK_REPLY_BAD_SEQUENCE] = bad_seq_resp;
        evt_set[pfer_pkg::EVT_PEER_LINK_UP_NOTICE] = link_up_rise;
        evt_set[pfer_pkg::EVT_CTRL_SYMBOL_UNUSED_SEQUENCE] = cs_checked && !seq_in_use;
    end

    assign pw_new = evt_set & i_pw_enable & pfer_pkg::PW_CAPABLE & {N{i_pw_permit}};

    ////////////////////////////////////////////////////////////////////////////////
    // edge history of the level inputs
    always_comb
    begin
        init_prev_d = i_link_init_done && i_peer_present;
        dead_prev_d = i_dead_link_expired;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            init_prev_q <= 1'b0;
            dead_prev_q <= 1'b0;
        end
        else
        begin
            init_prev_q <= init_prev_d;
            dead_prev_q <= dead_prev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sticky flags and drop command
    always_comb
    begin
        // set wins over a clear in the same cycle
        flags_d = (flags_q & ~i_evt_clear) | evt_set;
        fab_d = fab_q & ~i_fabric_clear;
        if (i_fabric_req_timeout)
        begin
            fab_d = fab_d | i_fabric_timeout_src;
        end
        drop_d = i_fabric_req_timeout;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            flags_q <= pfer_pkg::FLAGS_RST;
            fab_q <= '0;
            drop_q <= 1'b0;
        end
        else
        begin
            flags_q <= flags_d;
            fab_q <= fab_d;
            drop_q <= drop_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt follows the next flag values, so it rises with the flag
    always_comb
    begin
        irq_d = |(flags_d & i_irq_enable);
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // port-write request, held until taken
    always_comb
    begin
        pw_req_d = pw_req_q;
        pw_evt_d = pw_evt_q;
        if (i_pw_ack)
        begin
            pw_req_d = 1'b0;
            pw_evt_d = '0;
        end
        // a new enabled event re-arms the port-write even against an ack
        if (pw_new != '0)
        begin
            pw_req_d = 1'b1;
            pw_evt_d = pw_evt_d | pw_new;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            pw_req_q <= 1'b0;
            pw_evt_q <= '0;
        end
        else
        begin
            pw_req_q <= pw_req_d;
            pw_evt_q <= pw_evt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_drop_packet = drop_q;
    assign o_fabric_timeout_drop = flags_q[pfer_pkg::EVT_FABRIC_TIMEOUT_DROP];
    assign o_egress_discard = flags_q[pfer_pkg::EVT_EGRESS_DISCARD];
    assign o_global_fabric_timeout = flags_q[pfer_pkg::EVT_GLOBAL_FABRIC_TIMEOUT];
    assign o_replication_timeout = flags_q[pfer_pkg::EVT_REPLICATION_TIMEOUT];
    assign o_port_fault = flags_q[pfer_pkg::EVT_PORT_FAULT];
    assign o_ack_wait_expired = flags_q[pfer_pkg::EVT_ACK_WAIT_EXPIRED];
    assign o_link_reply_bad_sequence = flags_q[pfer_pkg::EVT_LINK_REPLY_BAD_SEQUENCE];
    assign o_peer_link_up_notice = flags_q[pfer_pkg::EVT_PEER_LINK_UP_NOTICE];
    assign o_ctrl_symbol_unused_sequence = flags_q[pfer_pkg::EVT_CTRL_SYMBOL_UNUSED_SEQUENCE];
    assign o_fabric_int_status = fab_q;
    assign o_lane_sync_fault = lane_fault_q;
    assign o_irq = irq_q;
    assign o_port_write_req = pw_req_q;
    assign o_port_write_events = pw_evt_q;

endmodule : pfer_event_reporter

// [rtl/pfer_lreq_tracker.sv]
// link-request retry tracker: times each link-response and counts failed tries
// assumes request and response strobes come from port logic on the same clock
module pfer_lreq_tracker #(
    parameter int TRIES = pfer_pkg::LREQ_TRIES
)
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // link maintenance strobes
    input wire logic i_lreq_sent,
    input wire logic i_lresp_rx,
    input wire logic i_no_outstanding,
    input wire logic [pfer_pkg::TIMEOUT_W-1:0] i_timeout_cycles,
    // results, one-cycle pulses
    output logic o_resp_timeout,
    output logic o_bad_seq_resp,
    output logic o_fatal
);

    typedef enum logic [0:0] {LRT_IDLE, LRT_WAIT} pfer_lrt_state_type;

    localparam logic [pfer_pkg::TRY_CNT_W-1:0] TRY_LAST = pfer_pkg::TRY_CNT_W'(TRIES - 1);

    pfer_lrt_state_type state_q, state_d;
    logic [pfer_pkg::TRY_CNT_W-1:0] bad_cnt_q, bad_cnt_d;
    logic [pfer_pkg::TRY_CNT_W-1:0] to_cnt_q, to_cnt_d;
    logic [pfer_pkg::TIMEOUT_W-1:0] timer_q, timer_d;
    logic timeout_q, timeout_d;
    logic bad_q, bad_d;
    logic fatal_q, fatal_d;

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        state_d = state_q;
        bad_cnt_d = bad_cnt_q;
        to_cnt_d = to_cnt_q;
        timer_d = timer_q;
        timeout_d = 1'b0;
        bad_d = 1'b0;
        fatal_d = 1'b0;
        case (state_q)
            LRT_IDLE:
            begin
                if (i_lreq_sent)
                begin
                    state_d = LRT_WAIT;
                    timer_d = '0;
                end
            end
            LRT_WAIT:
            begin
                timer_d = timer_q + 1'b1;
                if (i_lresp_rx)
                begin
                    state_d = LRT_IDLE;
                    if (i_no_outstanding)
                    begin
                        bad_d = 1'b1;
                        // fourth try answered with nothing outstanding is fatal
                        if (bad_cnt_q == TRY_LAST)
                        begin
                            fatal_d = 1'b1;
                            bad_cnt_d = '0;
                            to_cnt_d = '0;
                        end
                        else
                        begin
                            bad_cnt_d = bad_cnt_q + 1'b1;
                        end
                    end
                    else
                    begin
                        bad_cnt_d = '0;
                        to_cnt_d = '0;
                    end
                end
                else if (i_timeout_cycles != '0 && timer_q >= i_timeout_cycles - 1'b1)
                begin
                    state_d = LRT_IDLE;
                    timeout_d = 1'b1;
                    // fourth unanswered try is fatal
                    if (to_cnt_q == TRY_LAST)
                    begin
                        fatal_d = 1'b1;
                        bad_cnt_d = '0;
                        to_cnt_d = '0;
                    end
                    else
                    begin
                        to_cnt_d = to_cnt_q + 1'b1;
                    end
                end
                else if (i_lreq_sent)
                begin
                    timer_d = '0;
                end
            end
            default:
            begin
                state_d = LRT_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            state_q <= LRT_IDLE;
            bad_cnt_q <= '0;
            to_cnt_q <= '0;
            timer_q <= '0;
            timeout_q <= 1'b0;
            bad_q <= 1'b0;
            fatal_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            bad_cnt_q <= bad_cnt_d;
            to_cnt_q <= to_cnt_d;
            timer_q <= timer_d;
            timeout_q <= timeout_d;
            bad_q <= bad_d;
            fatal_q <= fatal_d;
        end
    end

    assign o_resp_timeout = timeout_q;
    assign o_bad_seq_resp = bad_q;
    assign o_fatal = fatal_q;

endmodule : pfer_lreq_tracker

// [rtl/pfer_pkg.sv]
// constants shared by the port fault event reporter and its link-request tracker
// assumes one core clock and a synchronous, active-high reset throughout
package pfer_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // event flag positions in the sticky flag vector
    localparam int EVT_COUNT = 9;
    localparam int EVT_FABRIC_TIMEOUT_DROP = 0;
    localparam int EVT_EGRESS_DISCARD = 1;
    localparam int EVT_GLOBAL_FABRIC_TIMEOUT = 2;
    localparam int EVT_REPLICATION_TIMEOUT = 3;
    localparam int EVT_PORT_FAULT = 4;
    localparam int EVT_ACK_WAIT_EXPIRED = 5;
    localparam int EVT_LINK_REPLY_BAD_SEQUENCE = 6;
    localparam int EVT_PEER_LINK_UP_NOTICE = 7;
    localparam int EVT_CTRL_SYMBOL_UNUSED_SEQUENCE = 8;

    // reset value of all sticky flags
    localparam logic [EVT_COUNT-1:0] FLAGS_RST = 9'h000;
    // events that may raise a port-write
    localparam logic [EVT_COUNT-1:0] PW_CAPABLE = 9'h1ff;

    ////////////////////////////////////////////////////////////////////////////////
    // link maintenance
    localparam int LREQ_TRIES = 4;
    localparam int TRY_CNT_W = 3;
    localparam int TIMEOUT_W = 24;
    localparam int SEQ_W_DEF = 6;
    localparam int LANES_DEF = 4;
    localparam int FAB_SRC_DEF = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // received control symbol kinds
    localparam logic [1:0] CS_PKT_ACCEPTED = 2'h0;
    localparam logic [1:0] CS_PKT_NOT_ACCEPTED = 2'h1;
    localparam logic [1:0] CS_RETRY = 2'h2;
    localparam logic [1:0] CS_OTHER = 2'h3;

endpackage : pfer_pkg

// [verif/pfer_event_reporter_monitor.sv]
// port-level assertions for the port fault event reporter
// assumes one clock and a synchronous active-high reset
module pfer_event_reporter_monitor #(
    parameter int LANES = 4,
    parameter int SEQ_W = 6
)
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // causes
    input wire logic i_fabric_req_timeout,
    input wire logic i_replication_timeout,
    input wire logic i_dead_link_expired,
    input wire logic [LANES-1:0] i_lane_sync_expired,
    input wire logic i_link_init_done,
    input wire logic i_peer_present,
    input wire logic [SEQ_W-1:0] i_seq_oldest,
    input wire logic [SEQ_W:0] i_seq_outstanding,
    input wire logic i_cs_rx,
    input wire logic [1:0] i_cs_kind,
    input wire logic [SEQ_W-1:0] i_cs_seq,
    input wire logic [pfer_pkg::EVT_COUNT-1:0] i_evt_clear,
    input wire logic i_pw_ack,
    // effects
    input wire logic o_drop_packet,
    input wire logic o_fabric_timeout_drop,
    input wire logic o_egress_discard,
    input wire logic o_global_fabric_timeout,
    input wire logic o_replication_timeout,
    input wire logic o_port_fault,
    input wire logic o_peer_link_up_notice,
    input wire logic o_ctrl_symbol_unused_sequence,
    input wire logic o_port_write_req
);
    timeunit 1ns;
    timeprecision 1ns;

    wire logic [SEQ_W-1:0] cs_dist = i_cs_seq - i_seq_oldest;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    a_drop_follows: assert property (i_fabric_req_timeout |=> o_drop_packet)
        else $error("no drop");
    a_fabric_flags: assert property (i_fabric_req_timeout |=>
        o_fabric_timeout_drop && o_egress_discard && o_global_fabric_timeout)
        else $error("fabric flags missing");
    a_replication_set: assert property (i_replication_timeout |=> o_replication_timeout)
        else $error("no replication flag");
    a_dead_fatal: assert property ($rose(i_dead_link_expired) |=> o_port_fault)
        else $error("dead link not fatal");
    a_lane_fatal: assert property (
        (i_lane_sync_expired & ~$past(i_lane_sync_expired)) != '0 |=> o_port_fault)
        else $error("lane sync not fatal");
    a_link_up_set: assert property ($rose(i_link_init_done && i_peer_present) |=>
        o_peer_link_up_notice)
        else $error("no link-up notice");
    a_cs_unused_set: assert property (i_cs_rx && i_cs_kind != pfer_pkg::CS_OTHER &&
        {1'b0, cs_dist} >= i_seq_outstanding |=> o_ctrl_symbol_unused_sequence)
        else $error("unused sequence missed");
    a_fault_sticky: assert property (o_port_fault && !i_evt_clear[4] |=> o_port_fault)
        else $error("port fault lost");
    a_pw_hold: assert property (o_port_write_req && !i_pw_ack |=> o_port_write_req)
        else $error("port-write dropped");

    c_drop: cover property (o_drop_packet);
    c_fault: cover property ($rose(o_port_fault));
    c_pw_ack: cover property (o_port_write_req && i_pw_ack);
endmodule : pfer_event_reporter_monitor

bind pfer_event_reporter pfer_event_reporter_monitor #(.LANES(LANES), .SEQ_W(SEQ_W)) i_monitor (
    .i_clk_sys, .i_sys_rst, .i_fabric_req_timeout, .i_replication_timeout, .i_dead_link_expired,
    .i_lane_sync_expired, .i_link_init_done, .i_peer_present, .i_seq_oldest, .i_seq_outstanding,
    .i_cs_rx, .i_cs_kind, .i_cs_seq, .i_evt_clear, .i_pw_ack, .o_drop_packet,
    .o_fabric_timeout_drop, .o_egress_discard, .o_global_fabric_timeout, .o_replication_timeout,
    .o_port_fault, .o_peer_link_up_notice, .o_ctrl_symbol_unused_sequence, .o_port_write_req);

// [verif/pfer_peer_model.sv]
// peer link port: answers each link-request with one link-response pulse
// assumes requests come on i_clk_sys; silent while i_answer is low
module pfer_peer_model
(
    // clock
    input wire logic i_clk_sys,
    // link maintenance
    input wire logic i_lreq_sent,
    input wire logic i_answer,
    output logic o_lresp_rx = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] wait_q = 2'h0;

    // a silent peer never answers, so the port's response timer runs out
    always @(posedge i_clk_sys)
    begin
        o_lresp_rx <= 1'b0;
        if (i_lreq_sent && i_answer)
            wait_q <= 2'h2;
        else if (wait_q != 2'h0)
        begin
            wait_q <= wait_q - 2'h1;
            o_lresp_rx <= (wait_q == 2'h1);
        end
    end
endmodule : pfer_peer_model

// [verif/test_pfer_event_reporter.sv]
// self-checking bench for the port fault event reporter
// assumes the rtl package and design, the peer model and a 10 MHz clock
module test_pfer_event_reporter;
    timeunit 1ns;
    timeprecision 1ns;

    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic fab_to = 1'b0, repl = 1'b0, lreq = 1'b0, dead = 1'b0, init = 1'b0, peer = 1'b0;
    logic cs_rx = 1'b0, pw_permit = 1'b0, pw_ack = 1'b0, answer = 1'b0;
    logic [7:0] fab_src = 8'h00, fab_clr = 8'h00;
    logic [3:0] lanes = 4'h0;
    logic [5:0] oldest = 6'h00, cs_seq = 6'h00;
    logic [6:0] outst = 7'h00;
    logic [1:0] cs_kind = 2'h0;
    logic [23:0] to_cyc = 24'h000003;
    logic [8:0] clr = 9'h000, irq_en = 9'h000, pw_en = 9'h000, exp_st = 9'h000, last = 9'h000;
    wire logic lresp, drop, irq, pw_req;
    wire logic [8:0] flags, pw_ev;
    wire logic [7:0] fab_st;
    wire logic [3:0] lane_f;
    logic [8:0] expq[$];
    int miscompares = 0, samples_checked = 0, cycles = 0;
    integer seed = 32'ha43677ab;

    always #50 i_clk_sys = ~i_clk_sys;

    pfer_event_reporter #(.LANES(4), .FAB_SRC(8), .SEQ_W(6)) i_dut (
        .i_clk_sys, .i_sys_rst, .i_fabric_req_timeout(fab_to), .i_fabric_timeout_src(fab_src),
        .i_replication_timeout(repl), .i_lreq_sent(lreq), .i_lresp_rx(lresp),
        .i_lresp_timeout_cycles(to_cyc), .i_dead_link_expired(dead),
        .i_lane_sync_expired(lanes), .i_link_init_done(init), .i_peer_present(peer),
        .i_seq_oldest(oldest), .i_seq_outstanding(outst), .i_cs_rx(cs_rx), .i_cs_kind(cs_kind),
        .i_cs_seq(cs_seq), .i_evt_clear(clr), .i_fabric_clear(fab_clr), .i_irq_enable(irq_en),
        .i_pw_enable(pw_en), .i_pw_permit(pw_permit), .i_pw_ack(pw_ack), .o_drop_packet(drop),
        .o_fabric_timeout_drop(flags[0]), .o_egress_discard(flags[1]),
        .o_global_fabric_timeout(flags[2]), .o_replication_timeout(flags[3]),
        .o_port_fault(flags[4]), .o_ack_wait_expired(flags[5]),
        .o_link_reply_bad_sequence(flags[6]), .o_peer_link_up_notice(flags[7]),
        .o_ctrl_symbol_unused_sequence(flags[8]), .o_fabric_int_status(fab_st),
        .o_lane_sync_fault(lane_f), .o_irq(irq), .o_port_write_req(pw_req),
        .o_port_write_events(pw_ev));

    pfer_peer_model i_peer (.i_clk_sys, .i_lreq_sent(lreq), .i_answer(answer), .o_lresp_rx(lresp));

    ////////////////////////////////////////
    task automatic chk(input logic [8:0] seen, input logic [8:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : tick

    // queue the next expected flag vector when it differs from the last one
    task automatic note(input logic [8:0] v);
        if (v !== exp_st)
            expq.push_back(v);
        exp_st = v;
    endtask : note

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse

    task automatic ev_clear(input string name);
        note(9'h000);
        clr = 9'h1ff;
        fab_clr = 8'hff;
        tick(1);
        clr = 9'h000;
        fab_clr = 8'h00;
        tick(2);
        $display("test %s done", name);
    endtask : ev_clear

    task automatic end_sim();
        if (expq.size() != 0)
            miscompares++;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////
    // any change of the flags must be the oldest expected one
    always @(negedge i_clk_sys)
    begin
        if (!i_sys_rst && flags !== last)
        begin
            chk(flags, (expq.size() != 0) ? expq.pop_front() : last);
            last = flags;
        end
        cycles++;
        if (cycles > 1500)
        begin
            miscompares++;
            end_sim();
        end
    end

    initial
    begin
        tick(6);
        i_sys_rst = 1'b0;
        fab_src = 8'h01 | 8'($random(seed));
        irq_en = 9'h001;
        pw_en = 9'h001;
        pw_permit = 1'b1;
        note(9'h007);
        pulse(fab_to);
        chk({8'h00, drop}, 9'h001);
        chk({1'b0, fab_st}, {1'b0, fab_src});
        chk({7'h00, irq, pw_req}, 9'h003);
        chk(pw_ev, 9'h001);
        tick(1);
        chk({8'h00, drop}, 9'h000);
        irq_en = 9'h000;
        pulse(pw_ack);
        chk({7'h00, irq, pw_req}, 9'h000);
        ev_clear("fabric");
        pw_permit = 1'b0;
        pw_en = 9'h1ff;
        irq_en = 9'h008;
        note(9'h008);
        pulse(repl);
        chk({7'h00, irq, pw_req}, 9'h002);
        ev_clear("replication");
        pw_permit = 1'b1;
        note(9'h010);
        dead = 1'b1;
        tick(3);
        chk({8'h00, pw_req}, 9'h001);
        dead = 1'b0;
        ev_clear("dead link");
        lanes = 4'h1 << 2'($random(seed));
        note(9'h010);
        tick(3);
        chk({5'h00, lane_f}, {5'h00, lanes});
        lanes = 4'h0;
        ev_clear("lane sync");
        note(9'h020);
        for (int i = 0; i < 4; i++)
        begin
            if (i == 3)
                note(9'h030);
            pulse(lreq);
            tick(8);
        end
        ev_clear("response timeout");
        answer = 1'b1;
        note(9'h040);
        // a good response in mid-run restarts the count of bad ones
        for (int i = 0; i < 8; i++)
        begin
            outst = (i == 3) ? 7'h01 : 7'h00;
            if (i == 7)
                note(9'h050);
            pulse(lreq);
            tick(5);
        end
        answer = 1'b0;
        outst = 7'h00;
        ev_clear("bad sequence");
        init = 1'b1;
        tick(2);
        note(9'h080);
        peer = 1'b1;
        tick(3);
        init = 1'b0;
        peer = 1'b0;
        ev_clear("link up");
        oldest = 6'($random(seed));
        outst = 7'h05;
        for (int k = 0; k < 4; k++)
        begin
            cs_kind = 2'(k);
            cs_seq = oldest + 6'h04;
            pulse(cs_rx);
            tick(1);
            if (k < 3)
                note(9'h100);
            cs_seq = oldest + 6'h05;
            pulse(cs_rx);
            tick(2);
            ev_clear("control symbol");
        end
        // a zero timeout disables the response timer, so no flag may move
        to_cyc = 24'h000000;
        pulse(lreq);
        tick(8);
        chk(flags, 9'h000);
        $display("test zero timeout done");
        tick(3);
        end_sim();
    end
endmodule : test_pfer_event_reporter
